// ===== acr_pkg.sv
// Summary of operation
// RULE1: thirty-two ones on serial input reset
// RULE2: reset clears logic, filter, modulator, registers
// RULE3: same reset happens at power-up
// RULE4: host waits 500 us before accesses
// RULE5: host may resync with ones run
// RULE6: unipolar result is straight binary
// RULE7: bipolar result is offset binary
// RULE8: fixed gain 128 scales input codes
// RULE9: result width 16 or 24 bits
// RULE10: polarity bit picks unipolar or bipolar
// RULE11: burnout bit drives both currents together
// RULE12: select 111 converts supply over six
// RULE13: select 110 converts temperature sensor
// RULE14: after reset expect communication register write
// RULE15: host holds input low in continuous read
// RULE16: out-of-range results saturate, never wrap
package acr_pkg;
  localparam int          ONES_RUN_LEN   = 32;
  localparam int          ONES_CNT_W     = 6;
  localparam int          CLK_MHZ        = 25;
  localparam int          SETTLE_US      = 500;
  localparam int          SETTLE_CYCLES  = SETTLE_US * CLK_MHZ;
  localparam int          SETTLE_CNT_W   = 14;
  localparam int          WIDTH_SHORT    = 16;
  localparam int          WIDTH_LONG     = 24;
  localparam int          GAIN           = 128;
  localparam int          ACC_W          = 32;
  localparam logic [2:0]  CH_SUPPLY_MON  = 3'h7;
  localparam logic [2:0]  CH_TEMP_SENSOR = 3'h6;
  localparam logic [2:0]  CH_DEFAULT     = 3'h0;
  localparam logic        POL_DEFAULT    = 1'h0;
  localparam logic        BURN_DEFAULT   = 1'h0;

  typedef enum logic [1:0] {
    REF_EXTERNAL,
    REF_INTERNAL
  } acr_ref_type;

  typedef enum logic [1:0] {
    SRC_ANALOG_IN,
    SRC_SUPPLY_DIV6,
    SRC_TEMP_SENSOR
  } acr_src_type;

  typedef struct packed {
    logic       unipolar;
    logic       burnout_current_enable;
    logic [2:0] channelSelect;
  } acr_cfg_type;

  typedef struct packed {
    acr_src_type source;
    acr_ref_type reference;
    logic        burnSource;
    logic        burnSink;
  } acr_route_type;
endpackage

// ===== acr_coder.sv
`timescale 1ns/10ps
module acr_coder
  import acr_pkg::*;
#(
  parameter int RES_W = WIDTH_LONG
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rstN,
  // input sample
  input  wire logic                    sampleValid,
  input  wire logic signed [ACC_W-1:0] sampleRatio,
  input  wire logic                    unipolar,
  // coded result
  output logic             [RES_W-1:0] resultCode,
  output logic                         resultValid
);
  // sampleRatio is AIN*128/VREF scaled by 2^(RES_W-1), signed
  localparam logic signed [ACC_W:0] MAXC = (ACC_W+1)'((64'(1) << RES_W) - 1);
  localparam logic signed [ACC_W:0] HALF = (ACC_W+1)'(64'(1) << (RES_W - 1));

  logic signed [ACC_W:0] raw;
  logic        [RES_W-1:0] codeD;

  always_comb begin
    // RULE6 RULE8 unipolar 2^N scaling
    if (unipolar) begin
      raw = {sampleRatio, 1'b0};
    // RULE7 RULE8 bipolar offset binary
    end else begin
      raw = {sampleRatio[ACC_W-1], sampleRatio} + HALF;
    end
    // RULE16 clamp not wrap
    if (raw < 0) begin
      codeD = '0;
    end else if (raw > MAXC) begin
      codeD = '1;
    end else begin
      codeD = raw[RES_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      resultCode  <= '0;
      resultValid <= 1'b0;
    end else begin
      resultValid <= sampleValid;
      if (sampleValid) begin
        resultCode <= codeD;
      end
    end
  end
endmodule

// ===== acr_top.sv
`timescale 1ns/10ps
module acr_top
  import acr_pkg::*;
#(
  parameter int SETTLE_COUNT = SETTLE_CYCLES,
  parameter int RES_W        = WIDTH_LONG
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // serial data input, bit strobe
  input  wire logic                    serialBit,
  input  wire logic                    serialStrobe,
  // configuration from register file
  input  wire logic                    cfgWrite,
  input  wire acr_cfg_type             cfgIn,
  // modulator sample
  input  wire logic                    sampleValid,
  input  wire logic signed [ACC_W-1:0] sampleRatio,
  // outputs
  output acr_cfg_type                  cfgOut,
  output acr_route_type                route,
  output logic                         coreReset,
  output logic                         ready,
  output logic                         expectCommWrite,
  output logic             [RES_W-1:0] resultCode,
  output logic                         resultValid
);
  logic                    rstSync1_q;
  logic                    rstSync2_q;
  logic [ONES_CNT_W-1:0]   onesCnt_q;
  logic                    softReset;
  logic [SETTLE_CNT_W-1:0] settle_q;
  logic                    rstN;
  acr_cfg_type             cfg_q;

  // RULE3 power-up reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end

  // RULE1 count consecutive ones
  always_ff @(posedge clk or negedge rstSync2_q) begin
    if (!rstSync2_q) begin
      onesCnt_q <= '0;
    end else if (softReset) begin
      onesCnt_q <= '0;
    end else if (serialStrobe) begin
      onesCnt_q <= serialBit ? onesCnt_q + 1'b1 : '0;
    end
  end

  assign softReset = serialStrobe && serialBit &&
                     (onesCnt_q == ONES_CNT_W'(ONES_RUN_LEN - 1));

  // RULE2 core reset copy
  always_ff @(posedge clk or negedge rstSync2_q) begin
    if (!rstSync2_q) begin
      coreReset <= 1'b1;
    end else begin
      coreReset <= softReset;
    end
  end

  assign rstN = rstSync2_q && !coreReset;

  // RULE4 settle window flag
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      settle_q <= '0;
    end else if (settle_q != SETTLE_CNT_W'(SETTLE_COUNT)) begin
      settle_q <= settle_q + 1'b1;
    end
  end

  assign ready = (settle_q == SETTLE_CNT_W'(SETTLE_COUNT));

  // RULE14 expect comm write
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      expectCommWrite <= 1'b1;
    end else if (serialStrobe) begin
      expectCommWrite <= 1'b0;
    end
  end

  // RULE2 registers default
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cfg_q <= '{unipolar: POL_DEFAULT, burnout_current_enable: BURN_DEFAULT,
                 channelSelect: CH_DEFAULT};
    end else if (cfgWrite) begin
      cfg_q <= cfgIn;
    end
  end

  assign cfgOut = cfg_q;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      route <= '{source: SRC_ANALOG_IN, reference: REF_EXTERNAL,
                 burnSource: 1'b0, burnSink: 1'b0};
    end else begin
      // RULE11 both currents together
      route.burnSource <= cfg_q.burnout_current_enable;
      route.burnSink   <= cfg_q.burnout_current_enable;
      // RULE12 supply monitor
      if (cfg_q.channelSelect == CH_SUPPLY_MON) begin
        route.source    <= SRC_SUPPLY_DIV6;
        route.reference <= REF_INTERNAL;
      // RULE13 temperature sensor
      end else if (cfg_q.channelSelect == CH_TEMP_SENSOR) begin
        route.source    <= SRC_TEMP_SENSOR;
        route.reference <= REF_INTERNAL;
      end else begin
        route.source    <= SRC_ANALOG_IN;
        route.reference <= REF_EXTERNAL;
      end
    end
  end

  // RULE9 RULE10 width and polarity
  acr_coder #(
    .RES_W (RES_W)
  ) uCoder (
    .clk         (clk),
    .rstN        (rstN),
    .sampleValid (sampleValid),
    .sampleRatio (sampleRatio),
    .unipolar    (cfg_q.unipolar),
    .resultCode  (resultCode),
    .resultValid (resultValid)
  );
endmodule

// ===== acr_host_model.sv
`timescale 1ns/10ps
module acr_host_model (
  // clock, status
  input  wire logic clk,
  input  wire logic ready,
  // serial line
  output logic      serialBit,
  output logic      serialStrobe
);
  initial begin
    serialBit = 1'h0;
    serialStrobe = 1'h0;
  end
  task automatic send(input logic b, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      serialBit = b;
      serialStrobe = 1'h1;
      @(negedge clk);
      serialStrobe = 1'h0;
      serialBit = 1'h0;
    end
  endtask
  task automatic settle(output int c);
    c = 0;
    while (ready !== 1'h1 && c < 100) begin
      @(negedge clk);
      c++;
    end
  endtask
endmodule

// ===== acr_properties.sv
`timescale 1ns/10ps
module acr_checker
  import acr_pkg::*;
#(
  parameter int RES_W = WIDTH_LONG
) (
  // clock, serial
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic                    serialBit,
  input wire logic                    serialStrobe,
  input wire logic                    sampleValid,
  input wire logic signed [ACC_W-1:0] sampleRatio,
  // outputs
  input wire acr_cfg_type             cfgOut,
  input wire acr_route_type           route,
  input wire logic                    coreReset,
  input wire logic                    ready,
  input wire logic                    expectCommWrite,
  input wire logic        [RES_W-1:0] resultCode,
  input wire logic                    resultValid
);
  logic [5:0] onesQ;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      onesQ <= 6'h0;
    else if (serialStrobe)
      onesQ <= (serialBit && onesQ != 6'h1F) ? onesQ + 6'h1 : 6'h0;
  end
  property p_ones; serialStrobe && serialBit && onesQ == 6'h1F |=> coreReset; endproperty
  a_ones: assert property (p_ones) else $error("ones run");
  property p_clr; coreReset |-> ##[1:2] (cfgOut == '0 && expectCommWrite && !ready); endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_val; sampleValid |=> resultValid; endproperty
  a_val: assert property (p_val) else $error("valid");
  property p_uni; sampleValid && cfgOut.unipolar && sampleRatio < 0 |=> resultCode == '0;
  endproperty
  a_uni: assert property (p_uni) else $error("uni");
  property p_bip; sampleValid && !cfgOut.unipolar && sampleRatio == 0
    |=> resultCode == {1'b1, {(RES_W-1){1'b0}}}; endproperty
  a_bip: assert property (p_bip) else $error("bip");
  property p_sup; !coreReset && !(serialStrobe && serialBit && onesQ == 6'h1F)
    && cfgOut.channelSelect == CH_SUPPLY_MON
    |=> route.source == SRC_SUPPLY_DIV6 && route.reference == REF_INTERNAL; endproperty
  a_sup: assert property (p_sup) else $error("sup");
  property p_tmp; !coreReset && !(serialStrobe && serialBit && onesQ == 6'h1F)
    && cfgOut.channelSelect == CH_TEMP_SENSOR
    |=> route.source == SRC_TEMP_SENSOR && route.reference == REF_INTERNAL; endproperty
  a_tmp: assert property (p_tmp) else $error("tmp");
  property p_brn; !coreReset && !(serialStrobe && serialBit && onesQ == 6'h1F)
    && cfgOut.burnout_current_enable
    |=> route.burnSource && route.burnSink; endproperty
  a_brn: assert property (p_brn) else $error("burn");
endmodule
bind acr_top acr_checker #(.RES_W(RES_W)) uChk (.clk(clk), .rst_n(rst_n),
  .serialBit(serialBit), .serialStrobe(serialStrobe), .sampleValid(sampleValid),
  .sampleRatio(sampleRatio), .cfgOut(cfgOut), .route(route), .coreReset(coreReset),
  .ready(ready), .expectCommWrite(expectCommWrite), .resultCode(resultCode),
  .resultValid(resultValid));

// ===== testbench.sv
`timescale 1ns/10ps
module testbench;
  import acr_pkg::*;
  localparam int SC = 20;
  localparam int RW = 16;
  logic clk, rst_n, sBit, sStb, cfgWrite, sampleValid, coreReset, ready, ecw, resultValid;
  acr_cfg_type cfgIn, cfgOut;
  acr_route_type route;
  logic signed [ACC_W-1:0] sampleRatio;
  logic [RW-1:0] resultCode;
  int n_fail = 0;
  int n_tests = 0;
  int c;
  acr_top #(.SETTLE_COUNT(SC), .RES_W(RW)) DUT (.clk(clk), .rst_n(rst_n), .serialBit(sBit),
    .serialStrobe(sStb), .cfgWrite(cfgWrite), .cfgIn(cfgIn), .sampleValid(sampleValid),
    .sampleRatio(sampleRatio), .cfgOut(cfgOut), .route(route), .coreReset(coreReset),
    .ready(ready), .expectCommWrite(ecw), .resultCode(resultCode), .resultValid(resultValid));
  acr_host_model HOST (.clk(clk), .ready(ready), .serialBit(sBit), .serialStrobe(sStb));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cfg(input logic u, input logic b, input logic [2:0] ch);
    @(negedge clk);
    cfgWrite = 1'h1;
    cfgIn = '{u, b, ch};
    @(negedge clk);
    cfgWrite = 1'h0;
    @(negedge clk);
  endtask
  task automatic t_code(input logic u);
    int r[6] = '{0, 16384, 32767, 32768, -32768, -40000};
    longint e;
    cfg(u, 1'h0, 3'h0);
    foreach (r[i]) begin
      e = u ? 2 * r[i] : r[i] + 32768;
      e = e < 0 ? 0 : (e > 65535 ? 65535 : e);
      @(negedge clk);
      sampleValid = 1'h1;
      sampleRatio = r[i];
      @(negedge clk);
      sampleValid = 1'h0;
      chk("code", e[31:0], {16'h0, resultCode});
      chk("valid", 1'h1, resultValid);
    end
  endtask
  task automatic t_route();
    for (int ch = 5; ch < 8; ch++) begin
      cfg(1'h0, ch[0], ch[2:0]);
      chk("src", ch == 7 ? SRC_SUPPLY_DIV6 : ch == 6 ? SRC_TEMP_SENSOR : SRC_ANALOG_IN,
        route.source);
      chk("ref", ch > 5 ? REF_INTERNAL : REF_EXTERNAL, route.reference);
      chk("burn", {ch[0], ch[0]}, {route.burnSource, route.burnSink});
    end
  endtask
  task automatic t_ones();
    cfg(1'h1, 1'h1, 3'h7);
    HOST.send(1'h1, 31);
    chk("comm", 1'h0, ecw);
    HOST.send(1'h0, 1);
    chk("keep", 5'h1F, cfgOut);
    chk("core", 1'h0, coreReset);
    HOST.send(1'h1, 32);
    chk("core", 1'h1, coreReset);
    repeat (3) @(negedge clk);
    chk("cfg", 5'h0, cfgOut);
    chk("comm", 1'h1, ecw);
    HOST.settle(c);
    chk("wait", SC + 1, c + 3);
  endtask
  task automatic results();
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    {rst_n, cfgWrite, sampleValid} = 3'h0;
    cfgIn = '0;
    sampleRatio = '0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    chk("comm", 1'h1, ecw);
    HOST.settle(c);
    chk("rdy", 1'h1, ready);
    t_code(1'h1);
    t_code(1'h0);
    t_route();
    t_ones();
    results();
  end
endmodule
